// ==== include/sadc_pkg.sv ====
// Purpose: shared types and constants for the serial converter readout
// Assumes: mclk at 50 MHz, link clock comes from the host
// Notes: counts are sclk edges counted from the select fall
package sadc_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int QUIET_NS = 50;
	localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQ_NS = 350;
	localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_W = 5;

	////////////////////////////////////////////////////////////////////////
	// frame layout, in sclk edges after select falls
	localparam int CODE_W = 8;
	localparam int CNT_W = 5;
	localparam logic [4:0] LEAD_ZEROS = 5'h03;
	localparam logic [4:0] TRAIL_ZEROS = 5'h04;
	localparam logic [4:0] LOAD_FALL = LEAD_ZEROS;
	localparam logic [4:0] FIRST_DATA_FALL = LEAD_ZEROS + 5'h01;
	localparam logic [4:0] LAST_DATA_FALL = LEAD_ZEROS + 5'h08;
	localparam logic [4:0] FRAME_FALLS = 5'h10;
	localparam logic [4:0] SHUTDOWN_FALL = 5'h02;
	localparam logic [4:0] NORMAL_FALL = 5'h0a;
	localparam logic [4:0] TRACK_RISE = 5'h0d;

	////////////////////////////////////////////////////////////////////////
	// modes and carriers
	typedef enum logic {SADC_SHUTDOWN, SADC_NORMAL} sadc_mode_e;
	localparam sadc_mode_e MODE_RST = SADC_SHUTDOWN;
	localparam logic [7:0] DUMMY_CODE = 8'h00;

	typedef struct packed {
		logic fall2;
		logic fall10;
		logic fall16;
		logic rise13;
	} sadc_link_s;

	typedef struct packed {
		logic normal_mode;
		logic holding;
		logic dummy_frame;
		logic powered;
		logic quiet_short;
		logic acq_short;
		logic aborted;
	} sadc_status_s;

endpackage

// ==== tb/sadc_host_model.sv ====
// Purpose: host serial controller that frames and reads results
// Assumes: sclk idles low and stands still between frames
// Notes: a released data line reads as the inverse of the last bit
`timescale 1ns/1ps
module sadc_host_model (
	// link out
	output logic sclk,
	output logic conversion_select_n,
	// link in
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic last_bit = 1'b0;
	// select-high gap after a frame; shortened only to provoke gap flags
	int gap_ns = 500;

	initial begin
		sclk = 1'b0;
		conversion_select_n = 1'b1;
	end

	// bits are taken at each rise, mid-way after the fall that shifted them
	task automatic frame(input int nf, input bit idle_low, output logic [15:0] got);
		got = 16'h0000;
		conversion_select_n = 1'b0;
		#200;
		for (int i = 0; i < nf; i++) begin
			sclk = 1'b1;
			last_bit = serial_result_oe ? serial_result_out : ~last_bit;
			if (i < 16) got[15 - i] = last_bit;
			#62.5 sclk = 1'b0;
			#62.5;
		end
		#62.5;
		if (idle_low) #300;
		conversion_select_n = 1'b1;
		#(gap_ns);
	endtask
endmodule

// ==== tb/sadc_top_sva.sv ====
// Purpose: port-level assertions for the serial readout
// Assumes: sees only the top module ports
// Notes: link counters clear on select high, like the design
`timescale 1ns/1ps
module sadc_top_sva (
	// clocks and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk,
	// link
	input wire logic conversion_select_n,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	// core and status
	input wire logic [7:0] sample_code,
	input wire sadc_pkg::sadc_status_s status
);
	logic [4:0] falls_q;
	logic [4:0] rises_q;
	logic [4:0] last_q;

	// saturate so a runaway clock cannot wrap back into the frame
	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) falls_q <= 5'h00;
		else if (falls_q != 5'h1f) falls_q <= falls_q + 5'h01;
	end
	always_ff @(posedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) rises_q <= 5'h00;
		else if (rises_q != 5'h1f) rises_q <= rises_q + 5'h01;
	end
	always_ff @(posedge conversion_select_n) begin
		last_q <= falls_q;
	end

	////////////////////////////////////////////////////////////////////////
	// two clock domains here, so every property names its own clock

	property p_oe_on;
		@(posedge mclk) disable iff (sys_rst)
		$fell(conversion_select_n) |-> ##[2:5] serial_result_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe late after select fall");
	property p_oe_sel;
		@(posedge mclk) disable iff (sys_rst)
		$rose(conversion_select_n) |-> ##[1:5] !serial_result_oe;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("oe held after select rise");
	property p_oe_16;
		@(posedge mclk) disable iff (sys_rst)
		$rose(falls_q == 5'h10) |-> ##[1:6] !serial_result_oe;
	endproperty
	a_oe_16: assert property (p_oe_16) else $error("oe held after last fall");
	property p_normal;
		@(posedge mclk) disable iff (sys_rst)
		$fell(conversion_select_n) |-> ##[3:7] status.normal_mode;
	endproperty
	a_normal: assert property (p_normal) else $error("no normal mode at start");
	property p_track;
		@(posedge mclk) disable iff (sys_rst)
		$rose(rises_q == 5'h0d) |-> ##[1:6] !status.holding;
	endproperty
	a_track: assert property (p_track) else $error("hold kept after rise 13");
	property p_shut;
		@(posedge mclk) disable iff (sys_rst)
		$rose(conversion_select_n) && last_q inside {[5'h02:5'h09]} |-> ##[2:8] !status.normal_mode;
	endproperty
	a_shut: assert property (p_shut) else $error("no shutdown on early abort");
	property p_trunc;
		@(posedge mclk) disable iff (sys_rst)
		$rose(conversion_select_n) && last_q inside {[5'h0a:5'h0f]} |-> ##[2:8] status.normal_mode && status.aborted;
	endproperty
	a_trunc: assert property (p_trunc) else $error("late abort mishandled");
	property p_stay;
		@(posedge mclk) disable iff (sys_rst)
		!status.normal_mode && conversion_select_n |=> !status.normal_mode;
	endproperty
	a_stay: assert property (p_stay) else $error("left shutdown with select high");
	property p_zero;
		@(posedge sclk) disable iff (conversion_select_n)
		(falls_q < 5'h04 || falls_q > 5'h0b) |-> !serial_result_out;
	endproperty
	a_zero: assert property (p_zero) else $error("padding bit not zero");
	// bit 11-n of the code is bit 3-n modulo 8
	property p_data;
		@(posedge sclk) disable iff (conversion_select_n)
		(falls_q inside {[5'h04:5'h0b]} && !status.dummy_frame) |-> serial_result_out == sample_code[3'h3 - falls_q[2:0]];
	endproperty
	a_data: assert property (p_data) else $error("result bit wrong");
endmodule

bind sadc_top sadc_top_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
	.conversion_select_n(conversion_select_n), .serial_result_out(serial_result_out),
	.serial_result_oe(serial_result_oe), .sample_code(sample_code), .status(status));

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the serial readout
// Assumes: host model drives the link at 8 MHz
// Notes: frames from shutdown read back as dummy zeros
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic sclk;
	logic conversion_select_n;
	logic serial_result_out;
	logic serial_result_oe;
	logic [7:0] sample_code = 8'h00;
	sadc_pkg::sadc_status_s status;
	logic [15:0] got;
	int num_errors = 0;
	int comparisons = 0;

	always #10 mclk = ~mclk;

	sadc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .conversion_select_n(conversion_select_n),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
		.sample_code(sample_code), .status(status));
	sadc_host_model u_host (.sclk(sclk), .conversion_select_n(conversion_select_n),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic run(input int nf, input logic [7:0] code, input bit idle_low);
		@(posedge mclk);
		#1 sample_code = code;
		u_host.frame(nf, idle_low, got);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_first();
		run(16, 8'ha5, 1'b0);
		check("dummy bits", got, 16'h0000);
		check("dummy flag", 16'(status.dummy_frame), 16'h0001);
		check("powered", 16'(status.powered), 16'h0001);
		run(16, 8'ha5, 1'b0);
		check("valid bits", got, 16'h0a50);
		check("mode", 16'(status.normal_mode), 16'h0001);
		$display("t_first done");
	endtask

	task automatic t_codes();
		logic [7:0] codes [4] = '{8'h00, 8'hff, 8'h81, 8'h3c};
		foreach (codes[i]) begin
			run(16, codes[i], i == 3);
			check("frame bits", got, {4'h0, codes[i], 4'h0});
			check("aborted", 16'(status.aborted), 16'h0000);
			check("oe", 16'(serial_result_oe), 16'h0000);
			check("holding", 16'(status.holding), 16'h0000);
		end
		$display("t_codes done");
	endtask

	// abort points on both sides of the 2nd and 10th falls
	task automatic t_modes();
		int nf [9] = '{2, 1, 16, 16, 1, 10, 15, 9, 16};
		bit md [9] = '{0, 0, 1, 1, 1, 1, 1, 0, 1};
		bit dm [9] = '{0, 0, 1, 0, 0, 0, 0, 0, 1};
		foreach (nf[i]) begin
			run(nf[i], 8'h5a, 1'b0);
			check("mode", 16'(status.normal_mode), 16'(md[i]));
			check("aborted", 16'(status.aborted), 16'(nf[i] >= 2 && nf[i] < 16));
			check("oe", 16'(serial_result_oe), 16'h0000);
			if (nf[i] == 16) begin
				check("dummy flag", 16'(status.dummy_frame), 16'(dm[i]));
				check("bits", got, dm[i] ? 16'h0000 : 16'h05a0);
			end
		end
		$display("t_modes done");
	endtask

	// a 13-fall frame then a 40 ns select gap: both spacing limits broken
	task automatic t_gaps();
		u_host.gap_ns = 40;
		run(13, 8'h3c, 1'b0);
		u_host.gap_ns = 500;
		run(16, 8'hc3, 1'b0);
		check("quiet short", 16'(status.quiet_short), 16'h0001);
		check("acq short", 16'(status.acq_short), 16'h0001);
		check("gap bits", got, 16'h0c30);
		run(16, 8'hc3, 1'b0);
		check("quiet short", 16'(status.quiet_short), 16'h0000);
		check("acq short", 16'(status.acq_short), 16'h0000);
		$display("t_gaps done");
	endtask

	task automatic t_reset();
		@(posedge mclk);
		#1 sys_rst = 1'b1;
		repeat (4) @(posedge mclk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge mclk);
		#1 check("status", 16'(status), 16'h0000);
		run(16, 8'h77, 1'b0);
		check("dummy bits", got, 16'h0000);
		$display("t_reset done");
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge mclk);
		t_first();
		t_codes();
		t_modes();
		t_gaps();
		t_reset();
		conclude();
	end

	// whole run is about 45 us
	initial begin
		#400000;
		num_errors++;
		$display("BAD watchdog expected finish seen hang");
		conclude();
	end
endmodule

// ==== verilog/sadc_sync.sv ====
// Purpose: two flip-flop level synchroniser
// Assumes: input levels hold for several destination clocks
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module sadc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// ==== verilog/sadc_top.sv ====
// Purpose: serial conversion frame and readout of an 8-bit converter
// Assumes: sclk is the host's link clock and stops between frames
// Notes: select high clears all link-side state, there is no reset pin
// Behaviour
// - select falling samples the input (loads the dummy code instead when in shutdown) and enables the serial output
// - select low enters normal mode and starts a conversion and transfer
// - hold ends and tracking resumes at the 13th sclk rise
// - output released after 16th sclk fall or at select rise
// - sixteen sclk cycles per sample; bits change on sclk falls
// - frame is four zeros, eight result bits MSB first, four zeros
// - result is straight binary, LSB is supply over 256
// - select rise between 2nd and 10th sclk fall aborts into shutdown
// - select rise before 2nd sclk fall leaves the mode unchanged
// - select rise after 10th, before 16th fall aborts, stays normal
// - shutdown lasts until select falls again
// - at least 50 ns quiet gap between release and next conversion
// - start from shutdown powers up; first result unusable, second valid
`timescale 1ns/1ps
module sadc_top (
	// system clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// serial link
	input wire logic sclk,
	input wire logic conversion_select_n,
	output logic serial_result_out,
	output logic serial_result_oe,
	// converter core
	input wire logic [7:0] sample_code,
	// status
	output sadc_pkg::sadc_status_s status
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} sadc_state_e;

	sadc_state_e state_q;
	logic cs_n_s;
	logic cs_n_prev_q;
	logic frame_start;
	logic frame_end;
	sadc_pkg::sadc_link_s link_raw;
	logic fall2_q;
	logic fall10_q;
	logic fall16_q;
	logic rise13_q;
	sadc_pkg::sadc_link_s link_s;
	sadc_pkg::sadc_link_s seen_q;
	sadc_pkg::sadc_link_s seen_now;
	sadc_pkg::sadc_mode_e mode_q;
	sadc_pkg::sadc_mode_e prev_mode_q;
	logic [7:0] held_code_q;
	logic code_valid_q;
	logic dummy_q;
	logic powered_q;
	logic holding_q;
	logic oe_q;
	logic oe_prev_q;
	logic [sadc_pkg::GAP_W-1:0] quiet_cnt_q;
	logic [sadc_pkg::GAP_W-1:0] acq_cnt_q;
	logic quiet_short_q;
	logic acq_short_q;
	logic aborted_q;

	// link domain
	logic [4:0] fall_cnt_q;
	logic [4:0] fall_cnt_d;
	logic [4:0] rise_cnt_q;
	logic vmeta_q;
	logic vsync_q;
	logic [7:0] code_lat_q;
	logic sdo_q;
	logic [4:0] bit_idx;

	////////////////////////////////////////////////////////////////////////
	// crossings into mclk

	// select is a pin: two flops before any mclk logic looks at it
	sadc_sync #(
		.W(1),
		.RST_VAL(1'b1)
	) u_cs_sync (
		.clk(mclk),
		.rst(sys_rst),
		.d(conversion_select_n),
		.q(cs_n_s)
	);

	// link flags are sticky within a frame, so a level crossing is enough
	sadc_sync #(
		.W(4),
		.RST_VAL(4'h0)
	) u_link_sync (
		.clk(mclk),
		.rst(sys_rst),
		.d(link_raw),
		.q(link_s)
	);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cs_n_prev_q <= 1'b1;
		end else begin
			cs_n_prev_q <= cs_n_s;
		end
	end

	assign frame_start = cs_n_prev_q & ~cs_n_s;
	assign frame_end = ~cs_n_prev_q & cs_n_s;

	// flags seen so far in this frame, including this cycle
	assign seen_now = seen_q | link_s;

	////////////////////////////////////////////////////////////////////////
	// frame sequencing

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (frame_start) begin
						state_q <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (frame_end) begin
						state_q <= ST_IDLE;
					end else if (seen_now.fall16) begin
						state_q <= ST_DONE;
					end
				end
				// select idling low after a full word; must rise first
				ST_DONE: begin
					if (frame_end) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// edge history; stale flags of the last frame may still be in the
	// synchroniser for a cycle or two, hence cleared on the start too
	always_ff @(posedge mclk) begin
		if (sys_rst || frame_start) begin
			seen_q <= '0;
		end else if (state_q != ST_IDLE) begin
			seen_q <= seen_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operating mode

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode_q <= sadc_pkg::MODE_RST;
			prev_mode_q <= sadc_pkg::MODE_RST;
		end else if (frame_start) begin
			prev_mode_q <= mode_q;
			mode_q <= sadc_pkg::SADC_NORMAL;
		end else if (frame_end && state_q == ST_FRAME) begin
			if (!seen_now.fall2) begin
				mode_q <= prev_mode_q;
			end else if (!seen_now.fall10) begin
				mode_q <= sadc_pkg::SADC_SHUTDOWN;
			end else begin
				mode_q <= sadc_pkg::SADC_NORMAL;
			end
		end
		// otherwise the mode holds, shutdown included
	end

	// the first frame out of shutdown is only a power-up cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dummy_q <= 1'b0;
			powered_q <= 1'b0;
		end else if (frame_start) begin
			dummy_q <= (mode_q == sadc_pkg::SADC_SHUTDOWN);
		end else if (frame_end && state_q == ST_FRAME && seen_now.fall2 && !seen_now.fall10) begin
			powered_q <= 1'b0;
		end else if (seen_now.fall16 && state_q == ST_FRAME) begin
			powered_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample and hold

	// the code is frozen at the start and stays put while valid is high,
	// which is what lets the link side read it across the domains
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			held_code_q <= 8'h00;
			code_valid_q <= 1'b0;
		end else if (frame_start) begin
			held_code_q <= (mode_q == sadc_pkg::SADC_SHUTDOWN) ? sadc_pkg::DUMMY_CODE : sample_code;
			code_valid_q <= 1'b1;
		end else if (frame_end) begin
			code_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			holding_q <= 1'b0;
		end else if (frame_start) begin
			holding_q <= 1'b1;
		end else if (seen_now.rise13 || frame_end) begin
			holding_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output enable

	// kept in mclk because the release on select rise needs no sclk edge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oe_q <= 1'b0;
		end else if (frame_start) begin
			oe_q <= 1'b1;
		end else if (frame_end || seen_now.fall16) begin
			oe_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oe_prev_q <= 1'b0;
		end else begin
			oe_prev_q <= oe_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gap checks

	// host-side spacing is only observed, never enforced
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			quiet_cnt_q <= '0;
		end else if (oe_prev_q && !oe_q) begin
			quiet_cnt_q <= sadc_pkg::GAP_W'(sadc_pkg::QUIET_CYC);
		end else if (quiet_cnt_q != '0) begin
			quiet_cnt_q <= quiet_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acq_cnt_q <= '0;
		end else if (link_s.rise13 && !seen_q.rise13 && state_q != ST_IDLE) begin
			acq_cnt_q <= sadc_pkg::GAP_W'(sadc_pkg::ACQ_CYC);
		end else if (acq_cnt_q != '0) begin
			acq_cnt_q <= acq_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			quiet_short_q <= 1'b0;
			acq_short_q <= 1'b0;
		end else if (frame_start) begin
			quiet_short_q <= (quiet_cnt_q != '0);
			acq_short_q <= (acq_cnt_q != '0);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || frame_start) begin
			aborted_q <= 1'b0;
		end else if (frame_end && state_q == ST_FRAME && seen_now.fall2) begin
			aborted_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			status <= '0;
		end else begin
			status.normal_mode <= (mode_q == sadc_pkg::SADC_NORMAL);
			status.holding <= holding_q;
			status.dummy_frame <= dummy_q;
			status.powered <= powered_q;
			status.quiet_short <= quiet_short_q;
			status.acq_short <= acq_short_q;
			status.aborted <= aborted_q;
		end
	end

	assign serial_result_oe = oe_q;

	////////////////////////////////////////////////////////////////////////
	// link domain: sclk falls

	// select high is the frame's own end, so it clears this side
	// asynchronously; sclk may be stopped by then
	always_comb begin
		fall_cnt_d = fall_cnt_q;
		if (fall_cnt_q != sadc_pkg::FRAME_FALLS) begin
			fall_cnt_d = fall_cnt_q + 5'h01;
		end
	end

	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			fall_cnt_q <= 5'h00;
		end else begin
			fall_cnt_q <= fall_cnt_d;
		end
	end

	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			fall2_q <= 1'b0;
			fall10_q <= 1'b0;
			fall16_q <= 1'b0;
		end else begin
			fall2_q <= fall2_q | (fall_cnt_d >= sadc_pkg::SHUTDOWN_FALL);
			fall10_q <= fall10_q | (fall_cnt_d >= sadc_pkg::NORMAL_FALL);
			fall16_q <= fall16_q | (fall_cnt_d == sadc_pkg::FRAME_FALLS);
		end
	end

	// code valid crosses as a level; the code itself is only read once
	// that level is through both flops
	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			vmeta_q <= 1'b0;
			vsync_q <= 1'b0;
		end else begin
			vmeta_q <= code_valid_q;
			vsync_q <= vmeta_q;
		end
	end

	// a code not yet through by the load edge reads as zero; only
	// possible if sclk runs far above the rated rate
	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			code_lat_q <= 8'h00;
		end else if (fall_cnt_d == sadc_pkg::LOAD_FALL) begin
			code_lat_q <= vsync_q ? held_code_q : 8'h00;
		end
	end

	assign bit_idx = sadc_pkg::LAST_DATA_FALL - fall_cnt_d;

	// zero while select first falls and on falls 1..3, data MSB first on
	// falls 4..11, zeros on falls 12..15
	always_ff @(negedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			sdo_q <= 1'b0;
		end else if (fall_cnt_d >= sadc_pkg::FIRST_DATA_FALL && fall_cnt_d <= sadc_pkg::LAST_DATA_FALL) begin
			sdo_q <= code_lat_q[bit_idx[2:0]];
		end else begin
			sdo_q <= 1'b0;
		end
	end

	assign serial_result_out = sdo_q;

	// one flop per flag, so each edge's process owns its own bits
	assign link_raw = '{fall2: fall2_q, fall10: fall10_q, fall16: fall16_q, rise13: rise13_q};

	////////////////////////////////////////////////////////////////////////
	// link domain: sclk rises

	always_ff @(posedge sclk or posedge conversion_select_n) begin
		if (conversion_select_n) begin
			rise_cnt_q <= 5'h00;
			rise13_q <= 1'b0;
		end else begin
			if (rise_cnt_q != sadc_pkg::TRACK_RISE) begin
				rise_cnt_q <= rise_cnt_q + 5'h01;
			end
			rise13_q <= rise13_q | (rise_cnt_q == sadc_pkg::TRACK_RISE - 5'h01);
		end
	end

endmodule
